/* File: cado_alarm_eval.sv */
/*
 * Constants package and the per-channel alarm evaluator of the channel alarm block.
 * Assumes readings, set points and hysteresis are signed 16-bit values in one scale.
 */
// What this block does
// - A channel alarms when its reading is above high or below low set point.
// - One system alarm event is posted while any configured channel is alarming.
// - The system alarm event can be selected as trigger source or stop source.
// - Only channels in the current scan are evaluated; others never alarm.
// - Monitoring waits for arming, then compares once per programmed scan interval.
// - Pre-trigger monitoring and alarm triggering need a pre-trigger count of one or more.
// - While armed, an in-scan alarm clears only once the reading is back inside by the hysteresis.
// - The tripping side is remembered and only its release threshold is used.
// - Exactly 32 digital alarm outputs exist, whatever the channel count.
// - Each channel has one output assignment; each output is the OR of its channels.
// - Assignment zero is the null output and routes the channel nowhere.
// - A host byte write per bank sets or clears outputs and overrides alarms.
// - Forced output values take precedence over alarm-driven levels.
// - The host can read the present state of all 32 outputs.
`default_nettype none

package cado_pkg;
   localparam int NUM_CH = 32;
   localparam int NUM_DO = 32;
   localparam int RD_W = 16;
   localparam int ASG_W = 6;
   localparam int CH_W = 5;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PRETRIG = 8'h04;
   localparam logic [7:0] OFS_INTERVAL = 8'h08;
   localparam logic [7:0] OFS_CHSEL = 8'h0C;
   localparam logic [7:0] OFS_HIGH = 8'h10;
   localparam logic [7:0] OFS_LOW = 8'h14;
   localparam logic [7:0] OFS_HYST = 8'h18;
   localparam logic [7:0] OFS_ASSIGN = 8'h1C;
   localparam logic [7:0] OFS_ALARMS = 8'h20;
   localparam logic [7:0] OFS_DOSET = 8'h24;
   localparam logic [7:0] OFS_DOCLR = 8'h28;
   localparam logic [7:0] OFS_DOREL = 8'h2C;
   localparam logic [7:0] OFS_DOSTATE = 8'h30;
   localparam logic [7:0] OFS_DOFORCED = 8'h34;
   localparam logic [7:0] OFS_INTSTAT = 8'h38;
   localparam logic [7:0] OFS_INTMASK = 8'h3C;
   localparam logic [7:0] OFS_CHENA = 8'h40;
   // Control register fields
   localparam int CTRL_ARM = 0;
   localparam int CTRL_TRIGSEL = 1;
   localparam int CTRL_STOPSEL = 2;
   // Interrupt status fields
   localparam int INT_ALARM = 0;
   localparam int INT_SWEEP = 1;
   localparam int INT_W = 2;
   // Reset values and the read data of unmapped offsets
   localparam logic [31:0] INTERVAL_RST = 32'h0000_00FF;
   localparam logic [ASG_W-1:0] ASSIGN_NULL = 6'h00;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

`timescale 1ns/1ns

module cado_alarm_eval
   import cado_pkg::*;
(
   input wire logic signed [RD_W-1:0] reading,
   input wire logic signed [RD_W-1:0] highSet,
   input wire logic signed [RD_W-1:0] lowSet,
   input wire logic signed [RD_W-1:0] hyst,
   input wire logic inScan,
   input wire logic inAlarm,
   input wire logic highSide,
   output logic alarmNext,
   output logic highSideNext
);
   // One guard bit so set point plus or minus hysteresis cannot wrap
   logic signed [RD_W:0] rdX;
   logic signed [RD_W:0] highRel;
   logic signed [RD_W:0] lowRel;

   always_comb begin
      rdX = {reading[RD_W-1], reading};
      highRel = {highSet[RD_W-1], highSet} - {hyst[RD_W-1], hyst};
      lowRel = {lowSet[RD_W-1], lowSet} + {hyst[RD_W-1], hyst};
      alarmNext = inAlarm;
      highSideNext = highSide;
      if (!inScan) begin
         alarmNext = 1'b0;
         highSideNext = 1'b0;
      end else if (!inAlarm) begin
         if (reading > highSet) begin
            alarmNext = 1'b1;
            highSideNext = 1'b1;
         end else if (reading < lowSet) begin
            alarmNext = 1'b1;
            highSideNext = 1'b0;
         end
      end else if (highSide) begin
         alarmNext = !(rdX < highRel);
      end else begin
         alarmNext = !(rdX > lowRel);
      end
   end
endmodule

`default_nettype wire

/* File: cado_alarm_props.sv */
/*
 * Port checker of the channel alarm block, bound to cado_alarm_top.
 * Assumes one clock, core_clk, and the asynchronous active-low rstn.
 */
`default_nettype none
`timescale 1ns/1ns

// ======================================================================
// Checker
module cado_alarm_props
   import cado_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [NUM_DO-1:0] alarmOut,
   input wire logic sysAlarm,
   input wire logic alarmTrigger,
   input wire logic alarmStop,
   input wire logic irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   logic reqTake;
   logic [31:0] laneData;
   logic [1:0] forceCnt;
   logic [31:0] setMask;
   logic [31:0] clrMask;
   assign reqTake = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign laneData = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}}
      & wb_dat_i;
   // Three edges after a forcing write the outputs must show it
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         forceCnt <= 2'h0;
         setMask <= 32'h0000_0000;
         clrMask <= 32'h0000_0000;
      end else if (reqTake && wb_we_i && (wb_adr_i == OFS_DOSET)) begin
         forceCnt <= 2'h3;
         setMask <= laneData;
         clrMask <= 32'h0000_0000;
      end else if (reqTake && wb_we_i && (wb_adr_i == OFS_DOCLR)) begin
         forceCnt <= 2'h3;
         setMask <= 32'h0000_0000;
         clrMask <= laneData;
      end else if (forceCnt != 2'h0) begin
         forceCnt <= forceCnt - 2'h1;
      end
   end
   property p_ack_resp; reqTake |=> wb_ack_o; endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
   property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0000_0000; endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");
   property p_rst_quiet; $rose(rstn) |-> alarmOut == 32'h0000_0000 && !sysAlarm && !irq; endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs live after reset");
   property p_set_force; forceCnt == 2'h1 |-> (alarmOut & setMask) == setMask; endproperty
   a_set_force: assert property (p_set_force) else $error("forced-true bit low");
   property p_clr_force; forceCnt == 2'h1 |-> (alarmOut & clrMask) == 32'h0000_0000; endproperty
   a_clr_force: assert property (p_clr_force) else $error("forced-false bit high");
   property p_stop_pulse; alarmStop |=> !alarmStop [*8]; endproperty
   a_stop_pulse: assert property (p_stop_pulse) else $error("stop events too close");
   property p_trig_pulse; alarmTrigger |=> !alarmTrigger [*8]; endproperty
   a_trig_pulse: assert property (p_trig_pulse) else $error("trigger events too close");
   property p_stop_sys; alarmStop |-> sysAlarm; endproperty
   a_stop_sys: assert property (p_stop_sys) else $error("stop without system alarm");
   property p_trig_sys; alarmTrigger |-> sysAlarm; endproperty
   a_trig_sys: assert property (p_trig_sys) else $error("trigger without system alarm");
endmodule

bind cado_alarm_top cado_alarm_props i_props (.core_clk(core_clk), .rstn(rstn),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .alarmOut(alarmOut), .sysAlarm(sysAlarm), .alarmTrigger(alarmTrigger),
   .alarmStop(alarmStop), .irq(irq));
`default_nettype wire

/* File: cado_alarm_top.sv */
/*
 * Channel alarm monitor with 32 digital alarm outputs, reached over classic Wishbone.
 * Assumes readings, scan window and acquisition trigger state come from logic on core_clk.
 */
// The implementer's own choices: register access over Wishbone and the address map.
`default_nettype none
`timescale 1ns/1ns

module cado_alarm_top
   import cado_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Reading stream from the scanner
   input wire logic sampleValid,
   input wire logic [CH_W-1:0] sampleChan,
   input wire logic signed [RD_W-1:0] sampleData,
   input wire logic acqTriggered,
   // Results
   output logic [NUM_DO-1:0] alarmOut,
   output logic sysAlarm,
   output logic alarmTrigger,
   output logic alarmStop,
   output logic irq
);
   typedef enum logic [1:0] {
      CADO_WAIT = 2'b01,
      CADO_SWEEP = 2'b10
   } cado_state_type;

   typedef struct packed {
      cado_state_type state;
      logic [2:0] ctrl;
      logic [15:0] pretrig;
      logic [31:0] interval;
      logic [31:0] tickCnt;
      logic [CH_W-1:0] chSel;
      logic [NUM_CH-1:0] chanEn;
      logic [NUM_CH-1:0][RD_W-1:0] highSet;
      logic [NUM_CH-1:0][RD_W-1:0] lowSet;
      logic [NUM_CH-1:0][RD_W-1:0] hyst;
      logic [NUM_CH-1:0][ASG_W-1:0] assignTo;
      logic [NUM_CH-1:0][RD_W-1:0] reading;
      logic [NUM_CH-1:0] alarm;
      logic [NUM_CH-1:0] highSide;
      logic [CH_W-1:0] sweepIdx;
      logic [NUM_DO-1:0] forceMask;
      logic [NUM_DO-1:0] forceVal;
      logic [NUM_DO-1:0] doOut;
      logic sysAlarm;
      logic trig;
      logic stop;
      logic [INT_W-1:0] intStat;
      logic [INT_W-1:0] intMask;
      logic irq;
      logic ack;
      logic [31:0] dat;
   } cado_regs_type;

   cado_regs_type s_reg;
   cado_regs_type s_next;

   // ==========================================================
   // Per-channel evaluator
   // ==========================================================
   logic evalAlarm;
   logic evalHigh;

   cado_alarm_eval u_eval (
      .reading(s_reg.reading[s_reg.sweepIdx]),
      .highSet(s_reg.highSet[s_reg.sweepIdx]),
      .lowSet(s_reg.lowSet[s_reg.sweepIdx]),
      .hyst(s_reg.hyst[s_reg.sweepIdx]),
      .inScan(s_reg.chanEn[s_reg.sweepIdx]),
      .inAlarm(s_reg.alarm[s_reg.sweepIdx]),
      .highSide(s_reg.highSide[s_reg.sweepIdx]),
      .alarmNext(evalAlarm),
      .highSideNext(evalHigh)
   );

   // ==========================================================
   // Alarm routing onto the 32 outputs
   // ==========================================================
   // Only codes 1..32 match an output; zero and codes above 32 route nowhere
   logic [NUM_DO-1:0][NUM_CH-1:0] routeHit;
   logic [NUM_DO-1:0] alarmDrive;

   for (genvar o = 0; o < NUM_DO; o++) begin : g_out
      for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
         assign routeHit[o][c] = s_reg.alarm[c] &&
            (s_reg.assignTo[c] == ASG_W'(o + 1));
      end
      assign alarmDrive[o] = |routeHit[o];
   end

   // ==========================================================
   // Next-state logic
   // ==========================================================
   logic busReq;
   logic busWr;
   logic busRd;
   logic [31:0] wrMask;
   logic [31:0] wrBits;
   logic monitorActive;
   logic tick;
   logic sweepEnd;
   logic [NUM_CH-1:0] alarmsAfter;
   logic [INT_W-1:0] intSet;

   always_comb begin
      s_next = s_reg;
      busReq = wb_cyc_i && wb_stb_i && !s_reg.ack;
      busWr = busReq && wb_we_i;
      busRd = busReq && !wb_we_i;
      wrMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      wrBits = wb_dat_i & wrMask;
      // Before the trigger only a nonzero pre-trigger count lets monitoring run
      monitorActive = s_reg.ctrl[CTRL_ARM] &&
         (acqTriggered || (s_reg.pretrig != 16'h0000));
      tick = 1'b0;
      sweepEnd = 1'b0;
      alarmsAfter = s_reg.alarm;
      intSet = '0;

      // Latest reading per channel, kept between scan intervals
      if (sampleValid) begin
         s_next.reading[sampleChan] = sampleData;
      end

      // Scan interval timer; comparisons happen only on its expiry
      if (!monitorActive) begin
         s_next.tickCnt = 32'h0000_0000;
      end else if (s_reg.tickCnt >= s_reg.interval) begin
         s_next.tickCnt = 32'h0000_0000;
         tick = 1'b1;
      end else begin
         s_next.tickCnt = s_reg.tickCnt + 32'h0000_0001;
      end

      s_next.trig = 1'b0;
      s_next.stop = 1'b0;
      case (s_reg.state)
         CADO_WAIT: begin
            if (tick) begin
               s_next.state = CADO_SWEEP;
               s_next.sweepIdx = '0;
            end
         end
         CADO_SWEEP: begin
            s_next.alarm[s_reg.sweepIdx] = evalAlarm;
            s_next.highSide[s_reg.sweepIdx] = evalHigh;
            alarmsAfter[s_reg.sweepIdx] = evalAlarm;
            s_next.sweepIdx = s_reg.sweepIdx + CH_W'(1);
            if (s_reg.sweepIdx == CH_W'(NUM_CH - 1)) begin
               s_next.state = CADO_WAIT;
               sweepEnd = 1'b1;
            end
         end
         default: begin
            s_next.state = CADO_WAIT;
         end
      endcase

      // A whole-scan decision posts one system alarm event
      if (sweepEnd) begin
         s_next.sysAlarm = |alarmsAfter;
         intSet[INT_SWEEP] = 1'b1;
         if (|alarmsAfter) begin
            intSet[INT_ALARM] = 1'b1;
            s_next.trig = s_reg.ctrl[CTRL_TRIGSEL] &&
               (s_reg.pretrig != 16'h0000);
            s_next.stop = s_reg.ctrl[CTRL_STOPSEL];
         end
      end

      // Disarming stops monitoring and drops all alarms
      if (!s_reg.ctrl[CTRL_ARM]) begin
         s_next.state = CADO_WAIT;
         s_next.alarm = '0;
         s_next.highSide = '0;
         s_next.sysAlarm = 1'b0;
         // A sweep ending while the arm bit is already low must not fire a trigger or stop event
         s_next.trig = 1'b0;
         s_next.stop = 1'b0;
      end

      // Bus writes
      if (busWr) begin
         case (wb_adr_i)
            OFS_CTRL: s_next.ctrl = wb_dat_i[2:0];
            OFS_PRETRIG: s_next.pretrig = wb_dat_i[15:0];
            OFS_INTERVAL: s_next.interval = wb_dat_i;
            OFS_CHSEL: s_next.chSel = wb_dat_i[CH_W-1:0];
            OFS_HIGH: s_next.highSet[s_reg.chSel] = wb_dat_i[RD_W-1:0];
            OFS_LOW: s_next.lowSet[s_reg.chSel] = wb_dat_i[RD_W-1:0];
            OFS_HYST: s_next.hyst[s_reg.chSel] = wb_dat_i[RD_W-1:0];
            OFS_ASSIGN: s_next.assignTo[s_reg.chSel] = wb_dat_i[ASG_W-1:0];
            OFS_CHENA: s_next.chanEn = wb_dat_i;
            OFS_DOSET: begin
               // One byte lane per bank; enabled ones force true
               s_next.forceMask = s_reg.forceMask | wrBits;
               s_next.forceVal = s_reg.forceVal | wrBits;
            end
            OFS_DOCLR: begin
               s_next.forceMask = s_reg.forceMask | wrBits;
               s_next.forceVal = s_reg.forceVal & ~wrBits;
            end
            OFS_DOREL: s_next.forceMask = s_reg.forceMask & ~wrBits;
            OFS_INTMASK: s_next.intMask = wb_dat_i[INT_W-1:0];
            default: begin
            end
         endcase
      end

      // Bus reads; the status read clears, but a new event in that cycle survives
      s_next.ack = busReq;
      s_next.dat = UNMAPPED_DATA;
      s_next.intStat = s_reg.intStat | intSet;
      if (busRd) begin
         case (wb_adr_i)
            OFS_CTRL: s_next.dat = {29'h0, s_reg.ctrl};
            OFS_PRETRIG: s_next.dat = {16'h0000, s_reg.pretrig};
            OFS_INTERVAL: s_next.dat = s_reg.interval;
            OFS_CHSEL: s_next.dat = {27'h0, s_reg.chSel};
            OFS_HIGH: s_next.dat = {{16{s_reg.highSet[s_reg.chSel][RD_W-1]}},
               s_reg.highSet[s_reg.chSel]};
            OFS_LOW: s_next.dat = {{16{s_reg.lowSet[s_reg.chSel][RD_W-1]}},
               s_reg.lowSet[s_reg.chSel]};
            OFS_HYST: s_next.dat = {{16{s_reg.hyst[s_reg.chSel][RD_W-1]}},
               s_reg.hyst[s_reg.chSel]};
            OFS_ASSIGN: s_next.dat = {26'h0, s_reg.assignTo[s_reg.chSel]};
            OFS_ALARMS: s_next.dat = s_reg.alarm;
            OFS_DOSTATE: s_next.dat = s_reg.doOut;
            OFS_DOFORCED: s_next.dat = s_reg.forceMask;
            OFS_INTSTAT: begin
               s_next.dat = {30'h0, s_reg.intStat};
               s_next.intStat = intSet;
            end
            OFS_INTMASK: s_next.dat = {30'h0, s_reg.intMask};
            OFS_CHENA: s_next.dat = s_reg.chanEn;
            default: s_next.dat = UNMAPPED_DATA;
         endcase
      end
      s_next.irq = |(s_next.intStat & s_next.intMask);

      // Forced bits win over alarm-driven levels bit by bit
      s_next.doOut = (s_reg.forceMask & s_reg.forceVal) |
         (~s_reg.forceMask & alarmDrive);
   end

   // ==========================================================
   // State register
   // ==========================================================
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         s_reg.state <= CADO_WAIT;
         s_reg.ctrl <= 3'h0;
         s_reg.pretrig <= 16'h0000;
         s_reg.interval <= INTERVAL_RST;
         s_reg.tickCnt <= 32'h0000_0000;
         s_reg.chSel <= '0;
         s_reg.chanEn <= '0;
         s_reg.highSet <= '0;
         s_reg.lowSet <= '0;
         s_reg.hyst <= '0;
         s_reg.assignTo <= {NUM_CH{ASSIGN_NULL}};
         s_reg.reading <= '0;
         s_reg.alarm <= '0;
         s_reg.highSide <= '0;
         s_reg.sweepIdx <= '0;
         s_reg.forceMask <= '0;
         s_reg.forceVal <= '0;
         s_reg.doOut <= '0;
         s_reg.sysAlarm <= 1'b0;
         s_reg.trig <= 1'b0;
         s_reg.stop <= 1'b0;
         s_reg.intStat <= '0;
         s_reg.intMask <= '0;
         s_reg.irq <= 1'b0;
         s_reg.ack <= 1'b0;
         s_reg.dat <= 32'h0000_0000;
      end else begin
         s_reg <= s_next;
      end
   end

   assign wb_dat_o = s_reg.dat;
   assign wb_ack_o = s_reg.ack;
   assign alarmOut = s_reg.doOut;
   assign sysAlarm = s_reg.sysAlarm;
   assign alarmTrigger = s_reg.trig;
   assign alarmStop = s_reg.stop;
   assign irq = s_reg.irq;
endmodule

`default_nettype wire

/* File: cado_alarm_top_test.sv */
/*
 * Self-checking testbench of the channel alarm block.
 * Assumes the checker binds itself and the output load model sits beside the block.
 */
`default_nettype none
`timescale 1ns/1ns

// ======================================================================
// Bench
module cado_alarm_top_test
   import cado_pkg::*;
;
   logic core_clk, rstn, wbCyc, wbStb, wbWe, wbAck, sampleValid, acqTriggered;
   logic sysAlarm, alarmTrigger, alarmStop, irq;
   logic [7:0] wbAdr;
   logic [3:0] wbSel;
   logic [31:0] wbDatW, wbDatR, rv, seed, alarmOut, doSeen, forceMask, forceVal;
   logic [4:0] sampleChan;
   logic signed [15:0] sampleData;
   logic alm[5];
   logic hs[5];
   int rd[5];
   int asg[5] = '{1, 2, 2, 0, 3};
   int cor[8] = '{100, 101, 95, 89, -91, -101, -91, -89};
   int nFail, checkCount;
   int nTrig, nStop, trigMark;

   cado_alarm_top i_dut (.core_clk(core_clk), .rstn(rstn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
      .wb_ack_o(wbAck), .sampleValid(sampleValid), .sampleChan(sampleChan),
      .sampleData(sampleData), .acqTriggered(acqTriggered), .alarmOut(alarmOut),
      .sysAlarm(sysAlarm), .alarmTrigger(alarmTrigger), .alarmStop(alarmStop), .irq(irq));
   cado_do_load i_load (.core_clk(core_clk), .rstn(rstn), .alarmOut(alarmOut),
      .seenLevel(doSeen));

   // Event pulses are counted so trigger and stop routing can be checked
   always @(posedge core_clk) begin
      if (alarmTrigger === 1'b1) nTrig++;
      if (alarmStop === 1'b1) nStop++;
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // Returns {inAlarm, trippedHigh}
   function automatic logic [1:0] eval(input int r, input logic a, input logic h);
      if (!a) return (r > 100) ? 2'b11 : ((r < -100) ? 2'b10 : 2'b00);
      if (h) return (r < 90) ? 2'b00 : 2'b11;
      return (r > -90) ? 2'b00 : 2'b10;
   endfunction
   function automatic logic [31:0] expOut();
      logic [31:0] o;
      o = {30'h0, alm[1] | alm[2], alm[0]};
      return (o & ~forceMask) | (forceVal & forceMask);
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checkCount++;
      if (seen !== exp) begin
         nFail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", checkCount, nFail);
      if (nFail == 0 && checkCount > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         input logic [3:0] s);
      int n;
      n = 0;
      @(posedge core_clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= w;
      wbAdr <= a;
      wbDatW <= d;
      wbSel <= s;
      do begin
         @(posedge core_clk);
         n++;
      end while (wbAck !== 1'b1 && n < 20);
      rv = wbDatR;
      if (n >= 20) nFail++;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
   endtask
   // Waits for a scan-evaluated interrupt, then clears it by reading
   task automatic sweep();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 400) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 400) nFail++;
      xfer(1'b0, OFS_INTSTAT, 32'h0, 4'hF);
      chk(rv & 32'h0000_0002, 32'h0000_0002);
      n = 0;
      while (irq !== 1'b0 && n < 4) begin
         @(posedge core_clk);
         n++;
      end
      chk({31'h0, irq}, 32'h0);
   endtask
   // The sweep in flight may still use old readings, so at least two see the new ones;
   // two evaluations of one reading always reach a settled alarm state
   task automatic round();
      logic [1:0] e;
      for (int c = 0; c < 5; c++) begin
         @(posedge core_clk);
         sampleValid <= 1'b1;
         sampleChan <= 5'(c);
         sampleData <= 16'(rd[c]);
      end
      @(posedge core_clk);
      sampleValid <= 1'b0;
      sweep();
      sweep();
      sweep();
      for (int c = 0; c < 4; c++) begin
         for (int k = 0; k < 2; k++) begin
            e = eval(rd[c], alm[c], hs[c]);
            alm[c] = e[1];
            hs[c] = e[0];
         end
      end
      xfer(1'b0, OFS_ALARMS, 32'h0, 4'hF);
      chk(rv, {28'h0, alm[3], alm[2], alm[1], alm[0]});
      xfer(1'b0, OFS_DOSTATE, 32'h0, 4'hF);
      chk(rv, expOut());
      chk(doSeen, expOut());
      chk({31'h0, sysAlarm}, {31'h0, alm[0] | alm[1] | alm[2] | alm[3]});
   endtask

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   initial begin
      repeat (40000) @(posedge core_clk);
      nFail++;
      complete_run();
   end
   initial begin
      {rstn, wbCyc, wbStb, wbWe, sampleValid, acqTriggered} = 6'h00;
      {wbAdr, wbSel, wbDatW, sampleChan, sampleData} = 65'h0;
      {forceMask, forceVal} = 64'h0;
      seed = 32'h5155_F2C7;
      for (int c = 0; c < 5; c++) begin
         alm[c] = 1'b0;
         hs[c] = 1'b0;
      end
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      xfer(1'b0, OFS_DOSTATE, 32'h0, 4'hF);
      chk(rv, 32'h0000_0000);
      xfer(1'b0, OFS_INTERVAL, 32'h0, 4'hF);
      chk(rv, INTERVAL_RST);
      xfer(1'b0, 8'hFC, 32'h0, 4'hF);
      chk(rv, UNMAPPED_DATA);
      for (int c = 0; c < 5; c++) begin
         xfer(1'b1, OFS_CHSEL, 32'(c), 4'hF);
         xfer(1'b0, OFS_ASSIGN, 32'h0, 4'hF);
         chk(rv, {26'h0, ASSIGN_NULL});
         xfer(1'b1, OFS_HIGH, 32'(100), 4'hF);
         xfer(1'b1, OFS_LOW, 32'(-100), 4'hF);
         xfer(1'b1, OFS_HYST, 32'(10), 4'hF);
         xfer(1'b1, OFS_ASSIGN, 32'(asg[c]), 4'hF);
      end
      xfer(1'b1, OFS_INTERVAL, 32'(40), 4'hF);
      xfer(1'b1, OFS_PRETRIG, 32'h0000_0001, 4'hF);
      xfer(1'b1, OFS_CHENA, 32'h0000_000F, 4'hF);
      xfer(1'b1, OFS_CTRL, 32'h0000_0007, 4'hF);
      // Masked: a scan completes within 100 cycles yet the line stays low
      repeat (100) @(posedge core_clk);
      chk({31'h0, irq}, 32'h0);
      xfer(1'b1, OFS_INTMASK, 32'h0000_0002, 4'hF);
      for (int i = 0; i < 14; i++) begin
         for (int c = 0; c < 5; c++) begin
            seed = xs(seed);
            rd[c] = int'(seed % 301) - 150;
         end
         if (i < 8) rd[0] = cor[i];
         round();
      end
      xfer(1'b1, OFS_DOSET, 32'h0000_FFF1, 4'h1);
      xfer(1'b1, OFS_DOCLR, 32'h0000_0002, 4'hF);
      forceMask = 32'h0000_00F3;
      forceVal = 32'h0000_00F1;
      xfer(1'b0, OFS_DOFORCED, 32'h0, 4'hF);
      chk(rv, forceMask);
      rd = '{200, -200, 0, 0, 0};
      round();
      chk({31'h0, (nTrig != 0) && (nStop != 0)}, 32'h0000_0001);
      xfer(1'b1, OFS_DOREL, 32'hFFFF_FFFF, 4'hF);
      forceMask = 32'h0000_0000;
      xfer(1'b0, OFS_DOSTATE, 32'h0, 4'hF);
      chk(rv, expOut());
      xfer(1'b1, OFS_CTRL, 32'h0000_0000, 4'hF);
      xfer(1'b0, OFS_ALARMS, 32'h0, 4'hF);
      chk(rv, 32'h0000_0000);
      for (int c = 0; c < 5; c++) alm[c] = 1'b0;
      xfer(1'b1, OFS_PRETRIG, 32'h0000_0000, 4'hF);
      xfer(1'b1, OFS_CTRL, 32'h0000_0007, 4'hF);
      repeat (150) @(posedge core_clk);
      xfer(1'b0, OFS_ALARMS, 32'h0, 4'hF);
      chk(rv, 32'h0000_0000);
      trigMark = nTrig;
      acqTriggered <= 1'b1;
      round();
      chk(32'(nTrig - trigMark), 32'h0000_0000);
      complete_run();
   end
endmodule
`default_nettype wire

/* File: cado_do_load.sv */
/*
 * Model of equipment listening to the 32 TTL alarm outputs.
 * Assumes it samples on core_clk; the lines are plain driven outputs.
 */
`default_nettype none
`timescale 1ns/1ns

// ======================================================================
// Sampling recorder
module cado_do_load
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [31:0] alarmOut,
   output logic [31:0] seenLevel
);
   // Receivers only sample; they never load the lines back
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         seenLevel <= 32'h0000_0000;
      end else begin
         seenLevel <= alarmOut;
      end
   end
endmodule
`default_nettype wire
